// ---- hw/dpsl_map.svh ----
// constants of the dual loop serial program latch: fields, offsets, reset values
`ifndef DPSL_MAP_SVH
`define DPSL_MAP_SVH
`define DPSL_SR_W 23
`define DPSL_CN_LO 0
`define DPSL_CN_HI 1
`define DPSL_R_LO 2
`define DPSL_R_HI 15
`define DPSL_T1_BIT 16
`define DPSL_T2_BIT 17
`define DPSL_LDS_BIT 18
`define DPSL_A_LO 2
`define DPSL_A_HI 8
`define DPSL_N_LO 9
`define DPSL_N_HI 19
`define DPSL_SW_BIT 20
`define DPSL_FC_BIT 21
`define DPSL_CS_BIT 22
`define DPSL_SEL_IF_REF 2'h0
`define DPSL_SEL_RF_REF 2'h1
`define DPSL_SEL_IF_DIV 2'h2
`define DPSL_SEL_RF_DIV 2'h3
`define DPSL_P_IF_HI 8'h20
`define DPSL_P_IF_LO 8'h40
`define DPSL_P_RF_HI 8'h40
`define DPSL_P_RF_LO 8'h80
`define DPSL_R_RST 14'h0003
`define DPSL_N_RST 11'h003
`define DPSL_A_RST 7'h00
`define DPSL_WIN_RST 8'h04
`define DPSL_GOOD_RST 4'h3
`define DPSL_REG_IF_REF 8'h00
`define DPSL_REG_IF_DIV 8'h04
`define DPSL_REG_RF_REF 8'h08
`define DPSL_REG_RF_DIV 8'h0C
`define DPSL_REG_STATUS 8'h10
`define DPSL_REG_LOCK_CFG 8'h14
`endif

// ---- hw/dpsl_pkg.sv ----
// types of the dual loop serial program latch
package dpsl_pkg;
   typedef struct packed {
      logic status_output_select;
      logic t2;
      logic t1;
      logic [13:0] ratio;
   } dpsl_ref_latch_t;
   typedef struct packed {
      logic cs;
      logic fc;
      logic sw;
      logic [10:0] n;
      logic [6:0] a;
   } dpsl_div_latch_t;
   typedef struct packed {
      logic [3:0] good_need;
      logic [7:0] window;
   } dpsl_lock_cfg_t;
   typedef enum logic [1:0] {
      LK_HUNT = 2'b01,
      LK_HELD = 2'b10
   } dpsl_lock_t;
endpackage

// ---- hw/dpsl_ref_div.sv ----
// reference divider: one pulse per ratio ticks of the reference oscillator
`timescale 1ns/1ns
module dpsl_ref_div #(
   parameter int W = 14
) (
   // clock and control
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic run_in,
   // reference ticks and ratio
   input wire logic tick_in,
   input wire logic [W-1:0] ratio_in,
   // divided output
   output logic pulse_out
);
   logic [W-1:0] cnt_r;
   logic pulse_r;
   wire wrap = tick_in && (cnt_r >= ratio_in - W'(1));
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !run_in) begin
         cnt_r <= '0;
         pulse_r <= 1'b0;
      end else begin
         cnt_r <= wrap ? '0 : (tick_in ? cnt_r + W'(1) : cnt_r);
         pulse_r <= wrap;
      end
   end
   assign pulse_out = pulse_r;
endmodule

// ---- hw/dpsl_main_div.sv ----
// main divider: pulse swallow division, one pulse per modulus*n + a input ticks
`timescale 1ns/1ns
module dpsl_main_div #(
   parameter int NW = 11,
   parameter int AW = 7,
   parameter int PW = 8
) (
   // clock and control
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic run_in,
   // oscillator ticks and ratios
   input wire logic tick_in,
   input wire logic [NW-1:0] n_in,
   input wire logic [AW-1:0] a_in,
   input wire logic [PW-1:0] modulus_in,
   // divided output
   output logic pulse_out
);
   localparam int TW = NW + PW + 1;
   logic [TW-1:0] cnt_r;
   logic pulse_r;
   // swallow counter adds a extra ticks on top of modulus times n
   wire [TW-1:0] total = TW'(modulus_in) * TW'(n_in) + TW'(a_in);
   wire wrap = tick_in && (cnt_r >= total - TW'(1));
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !run_in) begin
         cnt_r <= '0;
         pulse_r <= 1'b0;
      end else begin
         cnt_r <= wrap ? '0 : (tick_in ? cnt_r + TW'(1) : cnt_r);
         pulse_r <= wrap;
      end
   end
   assign pulse_out = pulse_r;
endmodule

// ---- hw/dpsl_top.sv ----
// dual loop serial program latch: shift register, four latches, dividers, lock detect
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "dpsl_map.svh"
module dpsl_top (
   // system clock and reset
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   // serial programming link
   input wire logic SER_CLK_IN,
   input wire logic SER_DATA_IN,
   input wire logic LATCH_LOAD_STROBE_IN,
   // oscillator and loop pins
   input wire logic REFERENCE_OSC_INPUT_IN,
   input wire logic IF_VCO_IN,
   input wire logic RF_VCO_IN,
   input wire logic IF_LOOP_SLEEP_N_IN,
   input wire logic RF_LOOP_SLEEP_N_IN,
   // charge pumps
   output logic IF_CP_OUT,
   output logic IF_CP_OE_OUT,
   output logic RF_CP_OUT,
   output logic RF_CP_OE_OUT,
   output logic IF_CP_HI_CURRENT_OUT,
   output logic RF_CP_HI_CURRENT_OUT,
   // prescaler modulus selects
   output logic IF_PRESCALER_RATIO_SELECT_OUT,
   output logic RF_PRESCALER_RATIO_SELECT_OUT,
   // status pin
   output logic SHARED_STATUS_PIN_OUT,
   // register port
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [31:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [31:0] REG_RDATA_OUT
);
   // link domain: shift register on the serial clock
   logic [`DPSL_SR_W-1:0] shift_r;
   always_ff @(posedge SER_CLK_IN) begin
      shift_r <= {shift_r[`DPSL_SR_W-2:0], SER_DATA_IN};
   end

   // pin synchronisers: strobe, osc, vco if, vco rf, sleep if, sleep rf
   logic [5:0] pin_s1_r;
   logic [5:0] pin_s2_r;
   logic [5:0] pin_s3_r;
   wire [5:0] pin_raw = {RF_LOOP_SLEEP_N_IN, IF_LOOP_SLEEP_N_IN, RF_VCO_IN, IF_VCO_IN,
      REFERENCE_OSC_INPUT_IN, LATCH_LOAD_STROBE_IN};
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         pin_s1_r <= 6'h00;
         pin_s2_r <= 6'h00;
         pin_s3_r <= 6'h00;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end
   wire [5:0] pin_rise = pin_s2_r & ~pin_s3_r;
   wire load_rise = pin_rise[0];
   wire osc_tick = pin_rise[1];
   wire [1:0] vco_tick = pin_rise[3:2];
   // sleep pins gate whole loops; a waking loop restarts from zero phase error
   wire [1:0] run = pin_s2_r[5:4];

   // word crossing: the shift register is idle while the strobe is high
   // since the host stops the serial clock, so a synced strobe edge qualifies it
   wire [1:0] load_sel = shift_r[`DPSL_CN_HI:`DPSL_CN_LO];
   wire [13:0] f_ratio = shift_r[`DPSL_R_HI:`DPSL_R_LO];
   wire f_t1 = shift_r[`DPSL_T1_BIT];
   wire f_t2 = shift_r[`DPSL_T2_BIT];
   wire f_lds = shift_r[`DPSL_LDS_BIT];
   wire [6:0] f_swallow = shift_r[`DPSL_A_HI:`DPSL_A_LO];
   wire [10:0] f_main = shift_r[`DPSL_N_HI:`DPSL_N_LO];
   wire f_sw = shift_r[`DPSL_SW_BIT];
   wire f_fc = shift_r[`DPSL_FC_BIT];
   wire f_cs = shift_r[`DPSL_CS_BIT];
   wire dpsl_pkg::dpsl_ref_latch_t ref_word = {f_lds, f_t2, f_t1, f_ratio};
   wire dpsl_pkg::dpsl_div_latch_t div_word = {f_cs, f_fc, f_sw, f_main, f_swallow};
   wire ld_if_ref = load_rise && (load_sel == `DPSL_SEL_IF_REF);
   wire ld_rf_ref = load_rise && (load_sel == `DPSL_SEL_RF_REF);
   wire ld_if_div = load_rise && (load_sel == `DPSL_SEL_IF_DIV);
   wire ld_rf_div = load_rise && (load_sel == `DPSL_SEL_RF_DIV);

   // four latches, each kept until its own select comes again
   dpsl_pkg::dpsl_ref_latch_t if_ref_r;
   dpsl_pkg::dpsl_ref_latch_t rf_ref_r;
   dpsl_pkg::dpsl_div_latch_t if_div_r;
   dpsl_pkg::dpsl_div_latch_t rf_div_r;
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         if_ref_r <= {3'h0, `DPSL_R_RST};
      end else if (ld_if_ref) begin
         if_ref_r <= ref_word;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         rf_ref_r <= {3'h0, `DPSL_R_RST};
      end else if (ld_rf_ref) begin
         rf_ref_r <= ref_word;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         if_div_r <= {3'h0, `DPSL_N_RST, `DPSL_A_RST};
      end else if (ld_if_div) begin
         if_div_r <= div_word;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         rf_div_r <= {3'h0, `DPSL_N_RST, `DPSL_A_RST};
      end else if (ld_rf_div) begin
         rf_div_r <= div_word;
      end
   end

   // lock detector settings written by software
   dpsl_pkg::dpsl_lock_cfg_t lock_cfg_r;
   wire wr_lock_cfg = REG_WR_IN && (REG_ADDR_IN == `DPSL_REG_LOCK_CFG);
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         lock_cfg_r <= {`DPSL_GOOD_RST, `DPSL_WIN_RST};
      end else if (wr_lock_cfg) begin
         lock_cfg_r <= REG_WDATA_IN[11:0];
      end
   end

   // per-loop settings, index 0 IF and 1 RF
   wire [13:0] ref_ratio [2];
   wire [10:0] main_n [2];
   wire [6:0] swallow_a [2];
   wire [7:0] modulus [2];
   wire [1:0] fc_pol = {rf_div_r.fc, if_div_r.fc};
   assign ref_ratio[0] = if_ref_r.ratio;
   assign ref_ratio[1] = rf_ref_r.ratio;
   assign main_n[0] = if_div_r.n;
   assign main_n[1] = rf_div_r.n;
   assign swallow_a[0] = if_div_r.a;
   assign swallow_a[1] = rf_div_r.a;
   assign modulus[0] = if_div_r.sw ? `DPSL_P_IF_HI : `DPSL_P_IF_LO;
   assign modulus[1] = rf_div_r.sw ? `DPSL_P_RF_HI : `DPSL_P_RF_LO;

   wire [1:0] fr_pulse;
   wire [1:0] fp_pulse;
   wire [1:0] loop_ok;
   wire [1:0] cp_level;
   wire [1:0] cp_drive;
   wire [1:0] loop_held;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_loop
         dpsl_ref_div #(.W(14)) u_ref (
            .clk_in(CLK_IN),
            .rst_n_in(RST_N_IN),
            .run_in(run[g]),
            .tick_in(osc_tick),
            .ratio_in(ref_ratio[g]),
            .pulse_out(fr_pulse[g])
         );
         dpsl_main_div #(.NW(11), .AW(7), .PW(8)) u_main (
            .clk_in(CLK_IN),
            .rst_n_in(RST_N_IN),
            .run_in(run[g]),
            .tick_in(vco_tick[g]),
            .n_in(main_n[g]),
            .a_in(swallow_a[g]),
            .modulus_in(modulus[g]),
            .pulse_out(fp_pulse[g])
         );

         // phase comparator: up after reference edge, down after divided edge
         logic up_r;
         logic dn_r;
         logic cp_r;
         logic oe_r;
         logic [7:0] err_r;
         logic [3:0] good_r;
         dpsl_pkg::dpsl_lock_t lk_r;
         dpsl_pkg::dpsl_lock_t lk_nxt;
         logic [3:0] good_nxt;
         wire up_set = up_r || fr_pulse[g];
         wire dn_set = dn_r || fp_pulse[g];
         wire compare_done = up_set && dn_set;
         wire err_small = err_r <= lock_cfg_r.window;
         // fc high: reference leading drives the pump high
         wire pump_lvl = fc_pol[g] ? up_r : dn_r;
         always_ff @(posedge CLK_IN) begin
            if (!RST_N_IN || !run[g]) begin
               up_r <= 1'b0;
               dn_r <= 1'b0;
               err_r <= 8'h00;
               cp_r <= 1'b0;
               oe_r <= 1'b0;
            end else begin
               up_r <= up_set && !compare_done;
               dn_r <= dn_set && !compare_done;
               err_r <= compare_done ? 8'h00 :
                  ((up_r ^ dn_r) && err_r != 8'hFF) ? err_r + 8'h01 : err_r;
               cp_r <= pump_lvl;
               oe_r <= up_r ^ dn_r; // equal phase leaves the pump off
            end
         end

         // lock detector: enough small errors in a row to lock, one large to drop
         always_comb begin
            lk_nxt = lk_r;
            good_nxt = good_r;
            case (lk_r)
               dpsl_pkg::LK_HUNT: begin
                  if (compare_done) begin
                     good_nxt = err_small ? good_r + 4'h1 : 4'h0;
                     if (err_small && good_r + 4'h1 >= lock_cfg_r.good_need) begin
                        lk_nxt = dpsl_pkg::LK_HELD;
                     end
                  end
               end
               dpsl_pkg::LK_HELD: begin
                  if (!err_small) begin
                     lk_nxt = dpsl_pkg::LK_HUNT;
                     good_nxt = 4'h0;
                  end
               end
               default: begin
                  lk_nxt = dpsl_pkg::LK_HUNT;
                  good_nxt = 4'h0;
               end
            endcase
         end
         always_ff @(posedge CLK_IN) begin
            if (!RST_N_IN || !run[g]) begin
               lk_r <= dpsl_pkg::LK_HUNT;
               good_r <= 4'h0;
            end else begin
               lk_r <= lk_nxt;
               good_r <= good_nxt;
            end
         end
         assign loop_held[g] = (lk_r == dpsl_pkg::LK_HELD);
         assign loop_ok[g] = loop_held[g] || !run[g];
         assign cp_level[g] = cp_r;
         assign cp_drive[g] = oe_r;
      end
   endgenerate

   // shared status pin: lock or comparator monitor
   wire lock_indication = &loop_ok;
   wire [3:0] monitor_src = {fp_pulse[1], fp_pulse[0], fr_pulse[1], fr_pulse[0]};
   wire monitor_bit = monitor_src[{if_ref_r.t2, if_ref_r.t1}];
   wire status_nxt = if_ref_r.status_output_select ? monitor_bit : lock_indication;
   wire [1:0] cur_nxt = {rf_div_r.cs, if_div_r.cs};
   wire [1:0] sw_nxt = {rf_div_r.sw, if_div_r.sw};
   logic status_r;
   logic [1:0] cur_r;
   logic [1:0] sw_r;
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         status_r <= 1'b0;
      end else begin
         status_r <= status_nxt;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         cur_r <= 2'h0;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         sw_r <= 2'h0;
      end else begin
         sw_r <= sw_nxt;
      end
   end

   // register read path, one cycle after the strobe; unmapped reads zero
   wire [31:0] status_word = {27'h0, run, loop_held, lock_indication};
   // decode kept apart from the mux so each address reads as a name
   wire sel_if_ref = (REG_ADDR_IN == `DPSL_REG_IF_REF);
   wire sel_if_div = (REG_ADDR_IN == `DPSL_REG_IF_DIV);
   wire sel_rf_ref = (REG_ADDR_IN == `DPSL_REG_RF_REF);
   wire sel_rf_div = (REG_ADDR_IN == `DPSL_REG_RF_DIV);
   wire sel_status = (REG_ADDR_IN == `DPSL_REG_STATUS);
   wire sel_lock_cfg = (REG_ADDR_IN == `DPSL_REG_LOCK_CFG);
   wire [31:0] rd_mux =
      sel_if_ref ? {15'h0, if_ref_r} :
      sel_if_div ? {11'h0, if_div_r} :
      sel_rf_ref ? {15'h0, rf_ref_r} :
      sel_rf_div ? {11'h0, rf_div_r} :
      sel_status ? status_word :
      sel_lock_cfg ? {20'h0, lock_cfg_r} : 32'h0;
   logic [31:0] rdata_r;
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         rdata_r <= 32'h0;
      end else begin
         rdata_r <= REG_RD_IN ? rd_mux : 32'h0;
      end
   end

   assign IF_CP_OUT = cp_level[0];
   assign IF_CP_OE_OUT = cp_drive[0];
   assign RF_CP_OUT = cp_level[1];
   assign RF_CP_OE_OUT = cp_drive[1];
   assign IF_CP_HI_CURRENT_OUT = cur_r[0];
   assign RF_CP_HI_CURRENT_OUT = cur_r[1];
   assign IF_PRESCALER_RATIO_SELECT_OUT = sw_r[0];
   assign RF_PRESCALER_RATIO_SELECT_OUT = sw_r[1];
   assign SHARED_STATUS_PIN_OUT = status_r;
   assign REG_RDATA_OUT = rdata_r;
endmodule

// ---- tb/dpsl_top_asserts.sv ----
// port checker of the dual loop program latch
`timescale 1ns/1ns
module dpsl_top_asserts (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   // watched inputs
   input wire logic IF_LOOP_SLEEP_N_IN,
   input wire logic RF_LOOP_SLEEP_N_IN,
   input wire logic LATCH_LOAD_STROBE_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [31:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   // watched outputs
   input wire logic IF_CP_OE_OUT,
   input wire logic RF_CP_OE_OUT,
   input wire logic IF_PRESCALER_RATIO_SELECT_OUT,
   input wire logic RF_CP_HI_CURRENT_OUT,
   input wire logic [31:0] REG_RDATA_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   sequence cfg_wr_s;
      REG_WR_IN && REG_ADDR_IN == 8'h14;
   endsequence
   sequence cfg_rd_s;
      REG_RD_IN && REG_ADDR_IN == 8'h14;
   endsequence
   rdata_idle_a: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0)
      else $error("read data outside its cycle");
   unmapped_read_a: assert property (REG_RD_IN && REG_ADDR_IN > 8'h14 |=> REG_RDATA_OUT == 32'h0)
      else $error("unmapped read not zero");
   status_width_a: assert property (REG_RD_IN && REG_ADDR_IN == 8'h10 |=> REG_RDATA_OUT[31:5] == 27'h0)
      else $error("status upper bits set");
   cfg_echo_a: assert property (cfg_wr_s ##2 cfg_rd_s |=>
      REG_RDATA_OUT == {20'h0, 12'($past(REG_WDATA_IN, 3))}) else $error("lock config echo wrong");
   if_sleep_a: assert property (!IF_LOOP_SLEEP_N_IN [*4] |=> !IF_CP_OE_OUT)
      else $error("if pump driven in sleep");
   rf_sleep_a: assert property (!RF_LOOP_SLEEP_N_IN [*4] |=> !RF_CP_OE_OUT)
      else $error("rf pump driven in sleep");
   if_sw_hold_a: assert property ($changed(IF_PRESCALER_RATIO_SELECT_OUT) |->
      $past(LATCH_LOAD_STROBE_IN, 2)) else $error("prescaler select moved without load");
   rf_cs_hold_a: assert property ($changed(RF_CP_HI_CURRENT_OUT) |->
      $past(LATCH_LOAD_STROBE_IN, 2)) else $error("current select moved without load");
endmodule

bind dpsl_top dpsl_top_asserts u_dpsl_top_asserts (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
   .IF_LOOP_SLEEP_N_IN(IF_LOOP_SLEEP_N_IN), .RF_LOOP_SLEEP_N_IN(RF_LOOP_SLEEP_N_IN),
   .LATCH_LOAD_STROBE_IN(LATCH_LOAD_STROBE_IN), .REG_ADDR_IN(REG_ADDR_IN),
   .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
   .IF_CP_OE_OUT(IF_CP_OE_OUT), .RF_CP_OE_OUT(RF_CP_OE_OUT),
   .IF_PRESCALER_RATIO_SELECT_OUT(IF_PRESCALER_RATIO_SELECT_OUT),
   .RF_CP_HI_CURRENT_OUT(RF_CP_HI_CURRENT_OUT), .REG_RDATA_OUT(REG_RDATA_OUT));

// ---- tb/dpsl_host_model.sv ----
// serial host model: shifts a word and pulses the load strobe
`timescale 1ns/1ns
module dpsl_host_model (
   // serial link
   output logic ser_clk_out,
   output logic ser_data_out,
   output logic le_out
);
   initial begin
      ser_clk_out = 1'b0;
      ser_data_out = 1'b0;
      le_out = 1'b0;
   end
   // msb first; odd offset keeps edges off the system clock edges
   task automatic send(input logic [22:0] w, input bit slow);
      #13;
      for (int i = 22; i >= 0; i--) begin
         ser_data_out = w[i];
         #32 ser_clk_out = 1'b1;
         #32 ser_clk_out = 1'b0;
         if (slow) #100;
      end
      ser_data_out = ~w[0]; // no stale level after the frame
      #200 le_out = 1'b1;
      #600 le_out = 1'b0;
      #600;
   endtask
endmodule

// ---- tb/dpsl_top_test.sv ----
// self-checking bench of the dual loop program latch
`timescale 1ns/1ns
module dpsl_top_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic osc = 1'b0;
   logic if_slp_n = 1'b0;
   logic rf_slp_n = 1'b0;
   logic if_vco = 1'b0;
   logic rf_vco = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic ser_clk, ser_data, le, if_cp, if_oe, rf_cp, rf_oe, if_hi, rf_hi, if_sw, rf_sw, stat;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   integer seed = 32'h4516D2C2;
   logic [31:0] shadow [4] = '{32'h3, 32'h3, 32'h180, 32'h180};
   logic [31:0] d;
   logic [20:0] b;
   always #50 clk = ~clk;
   dpsl_host_model u_host (.ser_clk_out(ser_clk), .ser_data_out(ser_data), .le_out(le));
   dpsl_top u_dpsl_top (.CLK_IN(clk), .RST_N_IN(rst_n), .SER_CLK_IN(ser_clk),
      .SER_DATA_IN(ser_data), .LATCH_LOAD_STROBE_IN(le), .REFERENCE_OSC_INPUT_IN(osc),
      .IF_VCO_IN(if_vco), .RF_VCO_IN(rf_vco), .IF_LOOP_SLEEP_N_IN(if_slp_n),
      .RF_LOOP_SLEEP_N_IN(rf_slp_n), .IF_CP_OUT(if_cp), .IF_CP_OE_OUT(if_oe),
      .RF_CP_OUT(rf_cp), .RF_CP_OE_OUT(rf_oe), .IF_CP_HI_CURRENT_OUT(if_hi),
      .RF_CP_HI_CURRENT_OUT(rf_hi), .IF_PRESCALER_RATIO_SELECT_OUT(if_sw),
      .RF_PRESCALER_RATIO_SELECT_OUT(rf_sw), .SHARED_STATUS_PIN_OUT(stat),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
      .REG_RDATA_OUT(rdata));
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail = n_fail + 1;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // select bit0 is the first control bit, so rf ref sits at 0x08
   function automatic logic [7:0] adr(input logic [1:0] s);
      return {4'h0, s[0], s[1], 2'b00};
   endfunction
   task automatic prog(input logic [1:0] s, input logic [20:0] body, input bit slow);
      u_host.send({body, s}, slow);
      shadow[s] = s[1] ? {11'h0, body} : {15'h0, body[16:0]};
   endtask
   task automatic check_all();
      for (int s = 0; s < 4; s++) begin
         reg_rd(adr(2'(s)), d);
         chk("latch", d, shadow[s]);
      end
   endtask
   // a random legal body; mode 0 gives the top of every range
   function automatic logic [20:0] rnd(input logic [1:0] s, input int mode);
      logic [10:0] n;
      logic [6:0] a;
      logic [13:0] r;
      n = mode == 0 ? 11'h7FF : 11'(3 + $unsigned($random(seed)) % 2045);
      a = mode == 0 ? 7'h7F : 7'($random(seed));
      r = mode == 0 ? 14'h3FFF : 14'(3 + $unsigned($random(seed)) % 16381);
      if (a >= n) a = 7'(n - 11'h1);
      return s[1] ? {3'($random(seed)), n, a} : {7'($random(seed)), r};
   endfunction
   task automatic count_mon(input int exp, input int len);
      int c;
      c = 0;
      repeat (len) begin
         @(posedge clk);
         osc <= ~osc;
         if_vco <= ~if_vco;
         rf_vco <= ~rf_vco;
         #1 c = c + int'(stat === 1'b1);
      end
      chk("monitor", 32'(c >= exp - 1 && c <= exp + 1), 32'h1);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      check_all();
      chk("pins", {if_oe, rf_oe, if_hi, rf_hi, if_sw, rf_sw}, 32'h0);
      reg_rd(8'h14, d);
      chk("cfg", d, 32'h304);
      // refused write, unmapped reads
      reg_wr(8'h00, $random(seed));
      reg_rd(8'h18, d);
      chk("unmapped", d, 32'h0);
      reg_rd(8'hFC, d);
      chk("unmapped", d, 32'h0);
      reg_rd(8'h00, d);
      chk("readonly", d, shadow[0]);
      repeat (3) begin
         d = $random(seed);
         reg_wr(8'h14, d);
         reg_rd(8'h14, d);
         chk("cfg", d, {20'h0, wdata[11:0]});
      end
      // every select, corner values first, then random, some slow
      for (int k = 0; k < 3; k++) begin
         for (int s = 0; s < 4; s++) begin
            b = rnd(2'(s), k);
            prog(2'(s), b, k == 1);
            if (s == 2) chk("if sel", {if_sw, if_hi}, {b[18], b[20]});
            if (s == 3) chk("rf sel", {rf_sw, rf_hi}, {b[18], b[20]});
         end
         check_all();
      end
      // both loops asleep count as good for lock
      prog(2'd0, {7'h00, 14'h3}, 1'b0);
      repeat (8) @(posedge clk);
      chk("lock pin", {31'h0, stat}, 32'h1);
      chk("pump", {if_oe, rf_oe, if_cp, rf_cp}, 32'h0);
      reg_rd(8'h10, d);
      chk("status", d & 32'h19, 32'h1);
      // running loops: monitor shows the divided reference
      if_slp_n <= 1'b1;
      rf_slp_n <= 1'b1;
      prog(2'd1, {7'h00, 14'h5}, 1'b0);
      prog(2'd0, {7'h04, 14'h3}, 1'b0);
      reg_rd(8'h10, d);
      chk("running", d & 32'h18, 32'h18);
      count_mon(20, 120);
      prog(2'd0, {7'h05, 14'h3}, 1'b0);
      count_mon(12, 120);
      // divided oscillator on the monitor: modulus 32, n 3, no swallow
      prog(2'd2, {3'h3, 11'h003, 7'h00}, 1'b0);
      prog(2'd0, {7'h06, 14'h3}, 1'b0);
      count_mon(500 / (32 * 3), 1000);
      final_report();
   end
endmodule
